// ### logic/hdlc_irq_sources.sv
`timescale 1ns/100ps
`include "hdlc_irq_map.svh"
// How it works
// - Interrupt mode: pool full at 32 bytes, message open
// - Interrupt mode: message end when message stored
// - DMA mode: message end after DMA read out
// - Overflow when fifo full and frame starts
// - Enabled frame start, two bytes after match/flag
// - Frame start latches control, address, status
// - Pool ready on reset command, or free half except in interrupt mode after end
// - Interrupt mode: pool ready when transparent frame completes after end
// - Auto mode: pool ready on positive acknowledge
// - Auto mode: repeat on negative acknowledge
// - Bus mode: repeat on collision after byte 32
// - Point mode: repeat on CTS loss after 32
// - Underrun when fifo empty without end indication
// - End indication from command or byte count
// - Layer-2 flags only in auto mode
// - Status change on RR/RNR against recorded peer
// - Protocol error on bad N(R) or S-info
// - Timer flag when timer and repeats expire
// - Interrupt holds until sources cleared by reading
// - Mask bits suppress primary indications individually
module hdlc_irq_sources
  import hdlc_irq_pkg::*;
#(
  parameter int TX_COUNT_W = 12,
  parameter int TIMER_W = 8,
  parameter int REPEAT_W = 3
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Datapath events
  input wire rx_events_t rx_ev,
  input wire tx_events_t tx_ev,
  input wire l2_events_t l2_ev,
  input wire frame_info_t rx_info,
  input wire logic timer_tick,
  // Interrupt request
  output logic irq_n
);
  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  logic ack_q;
  logic req;
  logic acc_rd;
  logic acc_wr;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign acc_rd = ce & avs_read & ack_q;
  assign acc_wr = ce & avs_write & ack_q;

  // One wait cycle, then accept
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [7:0] mask_q;
  logic [4:0] cfg_q;
  logic [TX_COUNT_W-1:0] tx_count_q;
  logic [TIMER_W-1:0] timer_val_q;
  logic [REPEAT_W-1:0] timer_rep_q;
  logic [4:0] cmd;
  logic dma_mode;
  logic auto_mode;

  assign cmd = (acc_wr && avs_address == `OFS_COMMAND) ? avs_writedata[4:0] : 5'h00;
  assign dma_mode = cfg_q[`CFG_DMA];
  assign auto_mode = cfg_q[`CFG_AUTO];

  // Writable registers
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= `MASK_RESET;
      cfg_q <= 5'h00;
      tx_count_q <= '0;
      timer_val_q <= '0;
      timer_rep_q <= '0;
    end else if (acc_wr) begin
      case (avs_address)
        `OFS_MASK: mask_q <= avs_writedata[7:0];
        `OFS_CONFIG: cfg_q <= avs_writedata[4:0];
        `OFS_TX_COUNT: tx_count_q <= avs_writedata[TX_COUNT_W-1:0];
        `OFS_TIMER: begin
          timer_val_q <= avs_writedata[TIMER_W-1:0];
          timer_rep_q <= avs_writedata[TIMER_W+REPEAT_W-1:TIMER_W];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Receive events
  // ----------------------------------------
  logic set_pool_full;
  logic set_msg_end;
  logic set_overflow;
  logic set_frame_start;
  logic fs_arm_q;
  logic [1:0] fs_cnt_q;
  logic fs_trigger;
  frame_info_t info_q;

  assign set_pool_full = ~dma_mode & rx_ev.block_full & rx_ev.msg_open;
  assign set_msg_end = dma_mode ? rx_ev.dma_read_done
                                : rx_ev.msg_stored;
  assign set_overflow = rx_ev.fifo_full & rx_ev.frame_begin;
  assign fs_trigger = cfg_q[`CFG_FS_EN] &
                      (cfg_q[`CFG_ADDR_MODE] ? rx_ev.addr_match : rx_ev.open_flag);
  assign set_frame_start = fs_arm_q & rx_ev.byte_rx & (fs_cnt_q == `FS_DELAY - 2'h1);

  // Two-byte delay after match or opening flag
  always_ff @(posedge clk) begin
    if (reset) begin
      fs_arm_q <= 1'b0;
      fs_cnt_q <= 2'h0;
    end else if (ce) begin
      if (fs_trigger) begin
        fs_arm_q <= 1'b1;
        fs_cnt_q <= 2'h0;
      end else if (set_frame_start) begin
        fs_arm_q <= 1'b0;
      end else if (fs_arm_q && rx_ev.byte_rx) begin
        fs_cnt_q <= fs_cnt_q + 2'h1;
      end
    end
  end

  // Header snapshot for the CPU at frame start
  always_ff @(posedge clk) begin
    if (reset) begin
      info_q <= '0;
    end else if (ce && set_frame_start) begin
      info_q <= rx_info;
    end
  end

  // ----------------------------------------
  // Transmit events
  // ----------------------------------------
  logic tx_active_q;
  logic xme_seen_q;
  logic transparent_q;
  logic [TX_COUNT_W-1:0] sent_q;
  logic cts_q;
  logic eom;
  logic past_pool;
  logic empty_q;
  logic set_pool_ready;
  logic set_repeat;
  logic set_underrun;

  assign eom = dma_mode ? (sent_q == tx_count_q) : xme_seen_q;
  assign past_pool = sent_q >= TX_COUNT_W'(`POOL_BYTES);
  assign set_pool_ready = tx_ev.half_free & (dma_mode | ~tx_active_q | ~xme_seen_q)
                        | cmd[`CMD_TRANSMITTER_RESET_CMD]
                        | ~dma_mode & tx_active_q & ~xme_seen_q & tx_ev.half_free
                        | ~dma_mode & xme_seen_q & transparent_q & tx_ev.frame_done
                        | auto_mode & l2_ev.ack_pos;
  assign set_repeat = auto_mode & l2_ev.nak
                    | cfg_q[`CFG_BUS] & tx_ev.collision & past_pool
                    | ~cfg_q[`CFG_BUS] & cts_q & ~tx_ev.cts & past_pool;
  assign set_underrun = tx_active_q & tx_ev.fifo_empty & tx_ev.shift_idle & ~eom & ~empty_q;

  // Frame tracking and shifted byte count
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_active_q <= 1'b0;
      xme_seen_q <= 1'b0;
      transparent_q <= 1'b0;
      sent_q <= '0;
    end else if (ce) begin
      if (cmd[`CMD_TRANSMITTER_RESET_CMD] || tx_ev.frame_done) begin
        tx_active_q <= 1'b0;
        xme_seen_q <= 1'b0;
      end else if (cmd[`CMD_XTF] || cmd[`CMD_XIF]) begin
        tx_active_q <= 1'b1;
        xme_seen_q <= cmd[`CMD_XME];
        transparent_q <= cmd[`CMD_XTF];
        sent_q <= '0;
      end else begin
        if (cmd[`CMD_XME]) begin
          xme_seen_q <= 1'b1;
        end
        if (tx_ev.byte_out) begin
          sent_q <= sent_q + TX_COUNT_W'(1);
        end
      end
    end
  end

  // Edge history for CTS loss and underrun one-shot
  always_ff @(posedge clk) begin
    if (reset) begin
      cts_q <= 1'b0;
      empty_q <= 1'b0;
    end else if (ce) begin
      cts_q <= tx_ev.cts;
      empty_q <= tx_ev.fifo_empty & tx_ev.shift_idle;
    end
  end

  // ----------------------------------------
  // Layer-2 events and timer
  // ----------------------------------------
  logic peer_ready_q;
  logic set_peer_change;
  logic set_proto_err;
  logic [TIMER_W-1:0] tcnt_q;
  logic [REPEAT_W-1:0] rcnt_q;
  logic trun_q;
  logic set_timer;

  assign set_peer_change = auto_mode & (l2_ev.rr & ~peer_ready_q | l2_ev.rnr & peer_ready_q);
  assign set_proto_err = auto_mode & (l2_ev.bad_nr | l2_ev.s_with_info);
  assign set_timer = trun_q & timer_tick & (tcnt_q == '0) & (rcnt_q == '0);

  // Recorded state of the peer receiver
  always_ff @(posedge clk) begin
    if (reset) begin
      peer_ready_q <= 1'b1;
    end else if (ce && auto_mode) begin
      if (l2_ev.rr) begin
        peer_ready_q <= 1'b1;
      end else if (l2_ev.rnr) begin
        peer_ready_q <= 1'b0;
      end
    end
  end

  // Timer with repeat counter
  always_ff @(posedge clk) begin
    if (reset) begin
      trun_q <= 1'b0;
      tcnt_q <= '0;
      rcnt_q <= '0;
    end else if (ce) begin
      if (cmd[`CMD_TIMER_GO]) begin
        trun_q <= 1'b1;
        tcnt_q <= timer_val_q;
        rcnt_q <= timer_rep_q;
      end else if (trun_q && timer_tick) begin
        if (tcnt_q != '0) begin
          tcnt_q <= tcnt_q - TIMER_W'(1);
        end else if (rcnt_q != '0) begin
          rcnt_q <= rcnt_q - REPEAT_W'(1);
          tcnt_q <= timer_val_q;
        end else begin
          trun_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Status registers, read clears, set wins
  // ----------------------------------------
  logic [3:0] pri_q;
  logic [5:0] ext_q;
  logic [3:0] pri_set;
  logic [5:0] ext_set;
  logic rd_pri;
  logic rd_ext;

  assign pri_set = {set_timer, set_pool_ready, set_msg_end, set_pool_full};
  assign ext_set = {set_proto_err, set_peer_change, set_underrun, set_repeat,
                    set_frame_start, set_overflow};
  assign rd_pri = acc_rd & (avs_address == `OFS_PRIMARY);
  assign rd_ext = acc_rd & (avs_address == `OFS_EXTENDED);

  // Sticky flags: a read clears only the flags it reported, so late events survive
  always_ff @(posedge clk) begin
    if (reset) begin
      pri_q <= 4'h0;
      ext_q <= 6'h00;
    end else if (ce) begin
      pri_q <= (pri_q & ~(rd_pri ? avs_readdata[3:0] : 4'h0)) | pri_set;
      ext_q <= (ext_q & ~(rd_ext ? avs_readdata[5:0] : 6'h00)) | ext_set;
    end
  end

  // Primary view with extended summary bit
  function automatic logic [7:0] primary_view(input logic [3:0] p, input logic [5:0] e);
    primary_view = {|e, 3'h0, p};
  endfunction : primary_view

  // Mask gates primary indications onto the pin
  assign irq_n = ~|(primary_view(pri_q, ext_q) & ~mask_q);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !ack_q) begin
      case (avs_address)
        `OFS_PRIMARY: avs_readdata <= {24'h000000, primary_view(pri_q, ext_q)};
        `OFS_EXTENDED: avs_readdata <= {26'h0000000, ext_q};
        `OFS_MASK: avs_readdata <= {24'h000000, mask_q};
        `OFS_CONFIG: avs_readdata <= {27'h0000000, cfg_q};
        `OFS_TX_COUNT: avs_readdata <= 32'(tx_count_q);
        `OFS_TIMER: avs_readdata <= 32'({timer_rep_q, timer_val_q});
        `OFS_RX_INFO: avs_readdata <= {12'h000, info_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_pool_full_dma: assert property (ce && dma_mode && rx_ev.block_full
    && !rd_pri && !pri_q[`PRI_POOL_FULL] |=> !pri_q[`PRI_POOL_FULL]) else $error("pool full raised in dma mode");
  chk_msg_end_dma: assert property (ce && dma_mode && rx_ev.dma_read_done
    |=> pri_q[`PRI_MSG_END]) else $error("message end missing after dma read");
  chk_msg_end_int: assert property (ce && !dma_mode && rx_ev.msg_stored
    |=> pri_q[`PRI_MSG_END]) else $error("message end missing in interrupt mode");
  chk_overflow_set: assert property (ce && rx_ev.fifo_full && rx_ev.frame_begin
    |=> ext_q[`EXT_OVERFLOW]) else $error("overflow not flagged");
  chk_frame_info: assert property (ce && set_frame_start
    |=> ext_q[`EXT_FRAME_START] && info_q == $past(rx_info)) else $error("frame header not held");
  chk_transmitter_reset_cmd_ready: assert property (ce && cmd[`CMD_TRANSMITTER_RESET_CMD]
    |=> pri_q[`PRI_POOL_READY]) else $error("pool ready missing after reset cmd");
  chk_l2_auto_only: assert property (ce && !auto_mode && !rd_ext && ext_q[5:4] == 2'h0
    && !set_underrun |=> ext_q[5:4] == 2'h0) else $error("layer-2 flag outside auto mode");
  chk_read_clears: assert property (rd_pri && pri_set == 4'h0
    |=> (pri_q & $past(avs_readdata[3:0])) == 4'h0) else $error("primary flags not cleared by read");
  chk_mask_all: assert property (mask_q == 8'hff |-> irq_n) else $error("masked interrupt reached pin");
  chk_bus_answer: assert property (ce && req && !ack_q ##1 ce && req
    |-> !avs_waitrequest) else $error("bus answer late");

  cov_frame_start: cover property (set_frame_start);
  cov_underrun: cover property (set_underrun);
  cov_irq_clear: cover property (!irq_n ##1 rd_pri ##1 irq_n);
endmodule : hdlc_irq_sources

// ### logic/hdlc_irq_map.svh
`ifndef HDLC_IRQ_MAP_SVH
`define HDLC_IRQ_MAP_SVH
// Register byte offsets
`define OFS_PRIMARY 5'h00
`define OFS_EXTENDED 5'h04
`define OFS_MASK 5'h08
`define OFS_CONFIG 5'h0c
`define OFS_COMMAND 5'h10
`define OFS_TX_COUNT 5'h14
`define OFS_TIMER 5'h18
`define OFS_RX_INFO 5'h1c
// Primary status bits
`define PRI_POOL_FULL 0
`define PRI_MSG_END 1
`define PRI_POOL_READY 2
`define PRI_TIMER 3
`define PRI_EXT_PENDING 7
// Extended status bits
`define EXT_OVERFLOW 0
`define EXT_FRAME_START 1
`define EXT_MSG_REPEAT 2
`define EXT_UNDERRUN 3
`define EXT_PEER_CHANGE 4
`define EXT_PROTO_ERR 5
// Config bits
`define CFG_DMA 0
`define CFG_AUTO 1
`define CFG_ADDR_MODE 2
`define CFG_BUS 3
`define CFG_FS_EN 4
// Command bits
`define CMD_TRANSMITTER_RESET_CMD 0
`define CMD_XTF 1
`define CMD_XIF 2
`define CMD_XME 3
`define CMD_TIMER_GO 4
// Reset values and counts
`define MASK_RESET 8'h00
`define POOL_BYTES 16'h0020
`define FS_DELAY 2'h2
`endif

// ### logic/hdlc_irq_pkg.sv
package hdlc_irq_pkg;
  // Receive side events from the datapath
  typedef struct packed {
    logic block_full;     // 32 bytes stored in rx fifo
    logic msg_open;       // current message not yet ended
    logic msg_stored;     // message or last part stored after crc and flag
    logic dma_read_done;  // dma finished reading complete message
    logic fifo_full;      // rx fifo full level
    logic frame_begin;    // new frame start seen
    logic addr_match;     // valid address match
    logic open_flag;      // opening flag seen
    logic byte_rx;        // one byte received
  } rx_events_t;
  // Transmit side events from the datapath
  typedef struct packed {
    logic half_free;      // 32-byte half empty and accessible
    logic frame_done;     // crc and closing flag shifted out
    logic byte_out;       // one data byte shifted out
    logic fifo_empty;     // transmit fifo empty level
    logic shift_idle;     // shifter has no data left
    logic collision;      // bus collision pulse
    logic cts;            // clear to send level
  } tx_events_t;
  // Layer-2 events from the frame decoder
  typedef struct packed {
    logic ack_pos;        // i-frame positively acknowledged
    logic nak;            // unexpected receive sequence number
    logic rr;             // rr frame received
    logic rnr;            // rnr frame received
    logic bad_nr;         // s- or i-frame with incorrect n(r)
    logic s_with_info;    // s-frame carrying an info field
  } l2_events_t;
  // Header fields captured at frame start
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [3:0] status;
  } frame_info_t;
endpackage : hdlc_irq_pkg

// ### verif/event_source.sv
`timescale 1ns/100ps
// ----------------------------------------
// Datapath event source model
// ----------------------------------------
module event_source
  import hdlc_irq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Events toward the block
  output rx_events_t rx_ev,
  output tx_events_t tx_ev,
  output l2_events_t l2_ev,
  output frame_info_t rx_info,
  output logic timer_tick
);
  rx_events_t rx_lvl = '0;
  tx_events_t tx_lvl = '0;
  // Idle state at time zero
  initial begin
    rx_ev = '0;
    tx_ev = '0;
    l2_ev = '0;
    rx_info = '0;
    timer_tick = 1'b0;
  end
  // Levels and header fields change just after an edge
  task automatic level(input rx_events_t r, input tx_events_t t, input frame_info_t f);
    @(posedge clk);
    rx_lvl = r;
    tx_lvl = t;
    rx_ev <= r;
    tx_ev <= t;
    rx_info <= f;
  endtask : level
  // One-cycle pulse over the standing levels, then an idle cycle
  task automatic pulse(input rx_events_t r = '0, input tx_events_t t = '0, input l2_events_t l = '0,
                       input logic k = 1'b0);
    @(posedge clk);
    rx_ev <= rx_lvl | r;
    tx_ev <= tx_lvl | t;
    l2_ev <= l;
    timer_tick <= k;
    @(posedge clk);
    rx_ev <= rx_lvl;
    tx_ev <= tx_lvl;
    l2_ev <= '0;
    timer_tick <= 1'b0;
  endtask : pulse
endmodule : event_source

// ### verif/tb.sv
`timescale 1ns/100ps
`include "hdlc_irq_map.svh"
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb;
  import hdlc_irq_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_n;
  rx_events_t rx_ev;
  tx_events_t tx_ev;
  l2_events_t l2_ev;
  frame_info_t rx_info;
  logic timer_tick;
  rx_events_t rl = '0;
  tx_events_t tl = '0;
  frame_info_t fi = '0;
  int n_errors = 0;
  int check_count = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // Block and its datapath partner
  hdlc_irq_sources uut (.clk(clk), .reset(reset), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_ev(rx_ev), .tx_ev(tx_ev), .l2_ev(l2_ev), .rx_info(rx_info),
    .timer_tick(timer_tick), .irq_n(irq_n));
  event_source src (.clk(clk), .rx_ev(rx_ev), .tx_ev(tx_ev), .l2_ev(l2_ev), .rx_info(rx_info),
    .timer_tick(timer_tick));
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // Compare one value
  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask : cmp
  // One bus access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 16) begin
      cmp("waitrequest", 32'h0, 32'h1);
      give_verdict();
    end
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string w, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(w, e, q);
  endtask : rd
  task automatic pri(input logic [31:0] e);
    rd("primary", `OFS_PRIMARY, e);
  endtask : pri
  task automatic ext(input logic [31:0] e);
    rd("extended", `OFS_EXTENDED, e);
  endtask : ext
  task automatic irq(input logic e);
    @(negedge clk);
    cmp("irq_n", {31'h0, e}, {31'h0, irq_n});
  endtask : irq
  task automatic lvl;
    src.level(rl, tl, fi);
  endtask : lvl
  // Expected status word with one flag
  function automatic logic [31:0] b(input int k);
    return 32'h1 << k;
  endfunction : b
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    int n;
    q = $urandom(32'h4f477823);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    irq(1'b1);
    rd("mask", `OFS_MASK, 32'h0);
    rd("command", `OFS_COMMAND, 32'h0);
    $display("test reset done");
    // Receive pool full and message end per mode
    wr(`OFS_CONFIG, 32'h0);
    rl.msg_open = 1'b1;
    lvl();
    src.pulse(.r('{block_full: 1'b1, default: 1'b0}));
    irq(1'b0);
    pri(b(`PRI_POOL_FULL));
    irq(1'b1);
    wr(`OFS_CONFIG, b(`CFG_DMA));
    src.pulse(.r('{block_full: 1'b1, msg_stored: 1'b1, default: 1'b0}));
    pri(32'h0);
    src.pulse(.r('{dma_read_done: 1'b1, default: 1'b0}));
    pri(b(`PRI_MSG_END));
    wr(`OFS_CONFIG, 32'h0);
    src.pulse(.r('{msg_stored: 1'b1, default: 1'b0}));
    pri(b(`PRI_MSG_END));
    // Clock enable low: the event is not taken
    @(posedge clk);
    ce <= 1'b0;
    src.pulse(.r('{block_full: 1'b1, default: 1'b0}));
    @(posedge clk);
    ce <= 1'b1;
    pri(32'h0);
    $display("test receive done");
    // Overflow only with a full fifo
    rl.fifo_full = 1'b1;
    lvl();
    src.pulse(.r('{frame_begin: 1'b1, default: 1'b0}));
    irq(1'b0);
    pri(b(`PRI_EXT_PENDING));
    ext(b(`EXT_OVERFLOW));
    irq(1'b1);
    rl.fifo_full = 1'b0;
    lvl();
    src.pulse(.r('{frame_begin: 1'b1, default: 1'b0}));
    ext(32'h0);
    $display("test overflow done");
    // Frame start two bytes late, in both recognition modes
    for (n = 0; n < 3; n++) begin
      fi = frame_info_t'($urandom);
      lvl();
      wr(`OFS_CONFIG, (n < 2 ? b(`CFG_FS_EN) : 32'h0) | (n[0] ? b(`CFG_ADDR_MODE) : 32'h0));
      src.pulse(.r('{addr_match: n[0], open_flag: ~n[0], default: 1'b0}));
      src.pulse(.r('{byte_rx: 1'b1, default: 1'b0}));
      ext(32'h0);
      src.pulse(.r('{byte_rx: 1'b1, default: 1'b0}));
      ext(n < 2 ? b(`EXT_FRAME_START) : 32'h0);
      if (n < 2) rd("rx info", `OFS_RX_INFO, {12'h0, fi});
    end
    $display("test frame start done");
    // Transmit pool ready
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_COMMAND, b(`CMD_TRANSMITTER_RESET_CMD));
    pri(b(`PRI_POOL_READY));
    wr(`OFS_COMMAND, b(`CMD_XTF));
    repeat (2) begin
      src.pulse(.t('{half_free: 1'b1, default: 1'b0}));
      pri(b(`PRI_POOL_READY));
    end
    wr(`OFS_COMMAND, b(`CMD_XME));
    src.pulse(.t('{frame_done: 1'b1, default: 1'b0}));
    pri(b(`PRI_POOL_READY));
    src.pulse(.l('{ack_pos: 1'b1, default: 1'b0}));
    pri(32'h0);
    wr(`OFS_CONFIG, b(`CFG_AUTO));
    src.pulse(.l('{ack_pos: 1'b1, default: 1'b0}));
    pri(b(`PRI_POOL_READY));
    $display("test pool ready done");
    // Message repeat: negative ack, collision, lost clear to send
    src.pulse(.l('{nak: 1'b1, default: 1'b0}));
    ext(b(`EXT_MSG_REPEAT));
    wr(`OFS_CONFIG, b(`CFG_BUS));
    wr(`OFS_COMMAND, b(`CMD_XTF) | b(`CMD_XME));
    repeat (31) src.pulse(.t('{byte_out: 1'b1, default: 1'b0}));
    src.pulse(.t('{collision: 1'b1, default: 1'b0}));
    ext(32'h0);
    repeat (1 + $urandom % 4) src.pulse(.t('{byte_out: 1'b1, default: 1'b0}));
    src.pulse(.t('{collision: 1'b1, default: 1'b0}));
    ext(b(`EXT_MSG_REPEAT));
    wr(`OFS_CONFIG, 32'h0);
    tl.cts = 1'b1;
    lvl();
    wr(`OFS_COMMAND, b(`CMD_XTF) | b(`CMD_XME));
    repeat (32) src.pulse(.t('{byte_out: 1'b1, default: 1'b0}));
    tl.cts = 1'b0;
    lvl();
    repeat (2) @(posedge clk);
    ext(b(`EXT_MSG_REPEAT));
    $display("test repeat done");
    // Underrun with and without an end indication
    for (n = 0; n < 4; n++) begin
      tl = '{cts: 1'b1, default: 1'b0};
      lvl();
      wr(`OFS_CONFIG, n > 1 ? b(`CFG_DMA) : 32'h0);
      wr(`OFS_TX_COUNT, 32'h3);
      wr(`OFS_COMMAND, b(`CMD_XTF) | (n == 1 ? b(`CMD_XME) : 32'h0));
      repeat (n == 2 ? 3 : 2) src.pulse(.t('{byte_out: 1'b1, default: 1'b0}));
      tl.fifo_empty = 1'b1;
      tl.shift_idle = 1'b1;
      lvl();
      repeat (2) @(posedge clk);
      ext(n[0] == n[1] ? b(`EXT_UNDERRUN) : 32'h0);
    end
    tl = '{cts: 1'b1, default: 1'b0};
    lvl();
    $display("test underrun done");
    // Layer-2 flags in auto mode only
    wr(`OFS_CONFIG, 32'h0);
    src.pulse(.l('{rr: 1'b1, bad_nr: 1'b1, s_with_info: 1'b1, default: 1'b0}));
    ext(32'h0);
    wr(`OFS_CONFIG, b(`CFG_AUTO));
    src.pulse(.l('{rr: 1'b1, default: 1'b0}));
    ext(32'h0);
    for (n = 0; n < 3; n++) begin
      src.pulse(.l('{rnr: n < 2, rr: n == 2, default: 1'b0}));
      ext(n == 1 ? 32'h0 : b(`EXT_PEER_CHANGE));
    end
    src.pulse(.l('{bad_nr: 1'b1, default: 1'b0}));
    ext(b(`EXT_PROTO_ERR));
    src.pulse(.l('{s_with_info: 1'b1, default: 1'b0}));
    ext(b(`EXT_PROTO_ERR));
    $display("test layer two done");
    // Masking of primary indications
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_MASK, b(`PRI_POOL_FULL) | b(`PRI_EXT_PENDING));
    rl.fifo_full = 1'b1;
    lvl();
    src.pulse(.r('{block_full: 1'b1, frame_begin: 1'b1, default: 1'b0}));
    irq(1'b1);
    src.pulse(.r('{msg_stored: 1'b1, default: 1'b0}));
    irq(1'b0);
    wr(`OFS_MASK, 32'hff);
    irq(1'b1);
    wr(`OFS_MASK, b(`PRI_POOL_FULL) | b(`PRI_EXT_PENDING));
    irq(1'b0);
    bus(1'b0, `OFS_PRIMARY, 32'h0, q);
    ext(b(`EXT_OVERFLOW));
    irq(1'b1);
    wr(`OFS_MASK, 32'h0);
    $display("test mask done");
    // Timer expiry after value and repeats run out
    wr(`OFS_TIMER, 32'h00000103);
    wr(`OFS_COMMAND, b(`CMD_TIMER_GO));
    src.pulse(.k(1'b1));
    pri(32'h0);
    repeat (20) src.pulse(.k(1'b1));
    pri(b(`PRI_TIMER));
    $display("test timer done");
    give_verdict();
  end
endmodule : tb
